// ==== src/ibus_pkg.sv ====
package ibus_pkg;

   // ----------------------------------------------------------------
   // Command codes (7-bit, eighth line ignored)
   // ----------------------------------------------------------------
   localparam logic [6:0] listen_base   = 7'h20;
   localparam logic [6:0] unlisten_code = 7'h3F;
   localparam logic [6:0] talk_base     = 7'h40;
   localparam logic [6:0] untalk_code   = 7'h5F;
   localparam logic [6:0] second_base   = 7'h60;
   localparam logic [6:0] second_top    = 7'h7E;
   localparam logic [6:0] ppoll_cfg     = 7'h05;
   localparam logic [6:0] ppoll_disable = 7'h70;
   localparam int         fifo_depth    = 16;
   localparam int         data_width    = 9;

   typedef enum logic [1:0] {
      hs_idle,
      hs_ready,
      hs_accept
   } hs_state_e;

   // Received byte with its end-of-message mark
   typedef struct packed {
      logic       eom;
      logic [7:0] data;
   } rx_word_s;

   // Decoded command event
   typedef struct packed {
      logic       talk;
      logic       untalk;
      logic       listen;
      logic       unlisten;
      logic       second;
      logic       pp_enable;
      logic       pp_disable;
      logic [4:0] addr;
   } cmd_s;

endpackage

// ==== src/ibus_fifo.sv ====
`timescale 1ns/1ps
module ibus_fifo #(
   parameter int width = 9,
   parameter int depth = 16
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [width-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [width-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int aw = $clog2(depth);

   logic [width-1:0] mem [depth];
   logic [aw-1:0]    wr_ptr;
   logic [aw-1:0]    rd_ptr;
   logic [aw:0]      count;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (count != (aw+1)'(depth));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) wr_ptr <= wr_ptr + 1'b1;
         if (pop)  rd_ptr <= rd_ptr + 1'b1;
         count <= count + (aw+1)'(push) - (aw+1)'(pop);
      end
   end
endmodule

// ==== src/ibus_port.sv ====
`timescale 1ns/1ps
module ibus_port #(
   parameter logic [4:0] my_addr = 5'h01,
   parameter int         depth   = ibus_pkg::fifo_depth
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic [7:0] dio_n_in,
   input  wire logic       dav_n_in,
   input  wire logic       atn_n_in,
   input  wire logic       eoi_n_in,
   input  wire logic       ifc_n_in,
   input  wire logic       ren_n_in,
   output logic            nrfd_n_out,
   output logic            nrfd_n_oe,
   output logic            ndac_n_out,
   output logic            ndac_n_oe,
   output logic            dio_n_out,
   output logic            dio_n_oe,
   output logic      [2:0] pp_line,
   input  wire logic       srq_req,
   output logic            srq_n_out,
   output logic            srq_n_oe,
   output logic      [7:0] rx_data,
   output logic            rx_eom,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   output ibus_pkg::cmd_s  cmd,
   output logic            cmd_valid,
   output logic            talker,
   output logic            listener,
   output logic            remote,
   output logic            poll_enabled,
   output logic            ifc_seen
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [12:0] sync1;
   logic [12:0] sync2;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= 13'h1FFF;
         sync2 <= 13'h1FFF;
      end else begin
         sync1 <= {ren_n_in, ifc_n_in, eoi_n_in, atn_n_in, dav_n_in,
                   dio_n_in};
         sync2 <= sync1;
      end
   end

   // Negative logic: a low line is true
   wire [7:0] bus_data = ~sync2[7:0];
   wire       dav      = ~sync2[8];
   wire       atn      = ~sync2[9];
   wire       eoi      = ~sync2[10];
   wire       ifc      = ~sync2[11];
   wire       ren      = ~sync2[12];

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   function automatic ibus_pkg::cmd_s decode(input logic [7:0] b,
                                             input logic       cfg);
      logic [6:0] c;
      decode = '0;
      c = b[6:0];
      decode.addr = c[4:0];
      decode.listen   = (c >= ibus_pkg::listen_base) &&
                        (c <  ibus_pkg::unlisten_code);
      decode.unlisten = (c == ibus_pkg::unlisten_code);
      decode.talk     = (c >= ibus_pkg::talk_base) &&
                        (c <  ibus_pkg::untalk_code);
      decode.untalk   = (c == ibus_pkg::untalk_code);
      decode.second   = (c >= ibus_pkg::second_base) &&
                        (c <= ibus_pkg::second_top);
      decode.pp_enable  = decode.second && cfg &&
                          (c < ibus_pkg::ppoll_disable);
      decode.pp_disable = decode.second && cfg &&
                          (c >= ibus_pkg::ppoll_disable);
   endfunction

   // ----------------------------------------------------------------
   // Acceptor handshake
   // ----------------------------------------------------------------
   ibus_pkg::hs_state_e state;
   ibus_pkg::hs_state_e next_state;
   logic                fifo_ready;
   logic                pp_cfg;
   logic [2:0]          pp_sel;
   logic                pp_on;

   // Commands are taken by every device; data only when listening
   wire involved  = atn || listener;
   wire can_take  = atn || fifo_ready;
   wire stall_data = !atn && !fifo_ready && !dav;
   wire take      = (state == ibus_pkg::hs_ready) && dav;
   ibus_pkg::cmd_s dec;
   assign dec = decode(bus_data, pp_cfg);

   always_comb begin
      next_state = state;
      case (state)
         ibus_pkg::hs_idle:
            if (involved && can_take && !dav) next_state = ibus_pkg::hs_ready;
         ibus_pkg::hs_ready:
            // Readiness won under attention is withdrawn when attention
            // drops with no room; a byte already valid then is still lost
            if (!involved || stall_data) next_state = ibus_pkg::hs_idle;
            else if (dav) next_state = ibus_pkg::hs_accept;
         ibus_pkg::hs_accept:
            if (!dav) next_state = ibus_pkg::hs_idle;
         default: next_state = ibus_pkg::hs_idle;
      endcase
   end

   // Open-drain: pull low (true) only while holding the line
   assign nrfd_n_out = 1'b0;
   assign nrfd_n_oe  = involved && (state != ibus_pkg::hs_ready);
   assign ndac_n_out = 1'b0;
   assign ndac_n_oe  = involved && (state != ibus_pkg::hs_accept);
   assign srq_n_out  = 1'b0;
   assign srq_n_oe   = srq_req;

   // Parallel poll answer on the assigned line while end and attention
   wire poll = atn && eoi;
   assign dio_n_out = 1'b0;
   assign dio_n_oe  = poll && pp_on;
   assign pp_line   = pp_sel;

   ibus_pkg::rx_word_s in_word;
   ibus_pkg::rx_word_s out_word;
   logic [ibus_pkg::data_width-1:0] out_bits;
   assign in_word  = '{eom: eoi, data: bus_data};
   assign out_word = ibus_pkg::rx_word_s'(out_bits);
   assign rx_data  = out_word.data;
   assign rx_eom   = out_word.eom;

   // Data bytes only with attention false
   wire data_take = take && !atn && listener;

   ibus_fifo #(
      .width (ibus_pkg::data_width),
      .depth (depth)
   ) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_data   (in_word),
      .in_valid  (data_take),
      .in_ready  (fifo_ready),
      .out_data  (out_bits),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   // ----------------------------------------------------------------
   // Addressing state
   // ----------------------------------------------------------------
   wire cmd_take = take && atn;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state        <= ibus_pkg::hs_idle;
         cmd          <= '0;
         cmd_valid    <= 1'b0;
         talker       <= 1'b0;
         listener     <= 1'b0;
         pp_cfg       <= 1'b0;
         pp_on        <= 1'b0;
         pp_sel       <= 3'h0;
         remote       <= 1'b0;
         ifc_seen     <= 1'b0;
      end else begin
         state     <= next_state;
         cmd_valid <= cmd_take;
         remote    <= ren;
         ifc_seen  <= ifc;
         if (cmd_take) begin
            cmd <= dec;
         end
         if (ifc) begin
            // Interface clear drops all addressing, in any state
            talker   <= 1'b0;
            listener <= 1'b0;
            pp_cfg   <= 1'b0;
         end else if (cmd_take) begin
            if (dec.untalk || (dec.talk && dec.addr != my_addr))
               talker <= 1'b0;
            if (dec.talk && dec.addr == my_addr)
               talker <= 1'b1;
            if (dec.unlisten) listener <= 1'b0;
            if (dec.listen && dec.addr == my_addr)
               listener <= 1'b1;
            pp_cfg <= listener && (bus_data[6:0] == ibus_pkg::ppoll_cfg);
            if (dec.pp_enable) begin
               pp_on  <= 1'b1;
               pp_sel <= bus_data[2:0];
            end
            if (dec.pp_disable) pp_on <= 1'b0;
         end
      end
   end
   assign poll_enabled = pp_on;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   untalk_clears_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.untalk && !ifc |=> !talker)
      else $error("untalk did not clear talker");

   talk_sets_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.talk && dec.addr == my_addr && !ifc |=> talker)
      else $error("own talk address missed");

   listen_sets_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.listen && dec.addr == my_addr && !ifc |=> listener)
      else $error("own listen address missed");

   parity_ignored_a: assert property (
      @(posedge clk) disable iff (!nrst)
      decode({1'b1, bus_data[6:0]}, pp_cfg) == dec)
      else $error("eighth bit changed decode");

   hold_ready_a: assert property (
      @(posedge clk) disable iff (!nrst)
      atn && state != ibus_pkg::hs_ready |-> nrfd_n_oe)
      else $error("not-ready released outside ready");

   hold_accept_a: assert property (
      @(posedge clk) disable iff (!nrst)
      take |=> !ndac_n_oe [*1] ##0 state == ibus_pkg::hs_accept)
      else $error("accept not signalled after valid");

   ifc_clears_a: assert property (
      @(posedge clk) disable iff (!nrst)
      ifc |=> !talker && !listener)
      else $error("interface clear kept addressing");

   poll_answer_a: assert property (
      @(posedge clk) disable iff (!nrst)
      poll && pp_on |-> dio_n_oe)
      else $error("parallel poll not answered");

   eom_kept_a: assert property (
      @(posedge clk) disable iff (!nrst)
      data_take && fifo_ready && eoi && !rx_valid |=> rx_valid && rx_eom)
      else $error("end mark lost");

   // ----------------------------------------------------------------
   // Handshake, addressing, poll, line and receive checks
   // ----------------------------------------------------------------
   // A full buffer must stall the talker rather than drop a byte; a byte already valid when attention drops onto a full buffer is dropped
   no_drop_full_a: assert property (
      @(posedge clk) disable iff (!nrst)
      data_take |-> fifo_ready)
      else $error("data byte taken into full buffer");

   accept_hold_a: assert property (
      @(posedge clk) disable iff (!nrst)
      state == ibus_pkg::hs_accept && dav |=> state == ibus_pkg::hs_accept)
      else $error("accept left while valid still true");

   retake_hold_a: assert property (
      @(posedge clk) disable iff (!nrst)
      take && involved && !ifc |=> nrfd_n_oe)
      else $error("not-ready not held after byte taken");

   ready_leave_a: assert property (
      @(posedge clk) disable iff (!nrst)
      state == ibus_pkg::hs_ready && !involved |=> state == ibus_pkg::hs_idle)
      else $error("ready kept while not involved");

   data_quiet_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !atn && !listener |-> !nrfd_n_oe && !ndac_n_oe)
      else $error("handshake driven for data while not listening");

   data_not_cmd_a: assert property (
      @(posedge clk) disable iff (!nrst)
      take && !atn |=> !cmd_valid)
      else $error("data byte reported as command");

   cmd_pulse_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take |=> cmd_valid && cmd == $past(dec))
      else $error("command not reported after take");

   talk_other_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.talk && dec.addr != my_addr && !ifc |=> !talker)
      else $error("other talk address kept talker");

   unlisten_clears_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.unlisten && !ifc |=> !listener)
      else $error("unlisten did not clear listener");

   pp_enable_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.pp_enable && !ifc
      |=> pp_on && pp_line == $past(bus_data[2:0]))
      else $error("poll enable not taken");

   pp_disable_a: assert property (
      @(posedge clk) disable iff (!nrst)
      cmd_take && dec.pp_disable && !ifc |=> !pp_on)
      else $error("poll disable not taken");

   poll_quiet_a: assert property (
      @(posedge clk) disable iff (!nrst)
      !poll |-> !dio_n_oe)
      else $error("data line driven outside poll");

   ifc_seen_a: assert property (
      @(posedge clk) disable iff (!nrst)
      ifc |=> ifc_seen)
      else $error("interface clear not flagged");

   remote_follow_a: assert property (
      @(posedge clk) disable iff (!nrst)
      ren != remote |=> remote == $past(ren))
      else $error("remote did not follow enable line");

   rx_stands_a: assert property (
      @(posedge clk) disable iff (!nrst)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data) && $stable(rx_eom))
      else $error("received word changed before taken");

   eom_clear_a: assert property (
      @(posedge clk) disable iff (!nrst)
      data_take && fifo_ready && !eoi && !rx_valid |=> rx_valid && !rx_eom)
      else $error("end mark set without end");
endmodule

// ==== bench/ibus_ctrl_model.sv ====
`timescale 1ns/1ps
// Controller and talker on the cable; the acceptor lines arrive here
// already resolved, since this side never pulls them itself.
module ibus_ctrl_model (
   input  wire logic       clk,
   input  wire logic       nrfd_n,
   input  wire logic       ndac_n,
   output logic      [7:0] dio_n,
   output logic            dav_n,
   output logic            atn_n,
   output logic            eoi_n,
   output logic            ifc_n,
   output logic            ren_n
);
   int slow = 0;
   initial begin
      dio_n = 8'hFF;
      {dav_n, atn_n, eoi_n, ifc_n, ren_n} = 5'h1F;
   end
   // Bounded waits, so a stalled acceptor comes back as ok low
   task automatic send(input logic [7:0] b, input logic atn,
                       input logic eoi, output logic ok);
      int n;
      ok = 1'b0;
      atn_n = ~atn;
      eoi_n = ~eoi;
      dio_n = ~b;
      repeat (3 + slow) @(negedge clk);
      for (n = 0; n < 100 && nrfd_n !== 1'b1; n++) @(negedge clk);
      if (nrfd_n === 1'b1) begin
         dav_n = 1'b0;
         for (n = 0; n < 100 && ndac_n !== 1'b1; n++) @(negedge clk);
         ok = ndac_n;
      end
      dav_n = 1'b1;
      repeat (1 + slow) @(negedge clk);
      dio_n = 8'hFF;
      eoi_n = 1'b1;
   endtask
endmodule

// ==== bench/ibus_port_tb.sv ====
`timescale 1ns/1ps
module ibus_port_tb;
   localparam logic [4:0] my = 5'h01;
   localparam int         dp = ibus_pkg::fifo_depth;
   logic clk = 1'b0, nrst = 1'b0, srq_req = 1'b0;
   logic rx_ready = 1'b1, rnd_rdy = 1'b0, ok;
   logic [7:0] m_dio, dio_w, pp_pull, rx_data;
   logic dav_n, atn_n, eoi_n, ifc_n, ren_n, nrfd_w, ndac_w;
   logic nrfd_n_out, nrfd_n_oe, ndac_n_out, ndac_n_oe;
   logic dio_n_out, dio_n_oe, srq_n_out, srq_n_oe;
   logic [2:0] pp_line, pl = 3'h0;
   logic rx_eom, rx_valid, cmd_valid, talker, listener;
   logic remote, poll_enabled, ifc_seen;
   logic t = 1'b0, l = 1'b0, p = 1'b0, cfg = 1'b0;
   ibus_pkg::cmd_s cmd, got;
   int mismatches = 0, n_checks = 0, n_cmd = 0, n;
   logic [8:0] exp_q[$];
   logic [7:0] cmds[8] = '{8'h21, 8'hC1, 8'h43, 8'h41, 8'h5F, 8'hBF,
                           8'h7E, 8'h60};

   ibus_port #(.my_addr(my), .depth(dp)) i_dut (
      .clk, .nrst, .dio_n_in(dio_w), .dav_n_in(dav_n),
      .atn_n_in(atn_n), .eoi_n_in(eoi_n), .ifc_n_in(ifc_n),
      .ren_n_in(ren_n), .nrfd_n_out, .nrfd_n_oe, .ndac_n_out,
      .ndac_n_oe, .dio_n_out, .dio_n_oe, .pp_line, .srq_req,
      .srq_n_out, .srq_n_oe, .rx_data, .rx_eom, .rx_valid,
      .rx_ready, .cmd, .cmd_valid, .talker, .listener, .remote,
      .poll_enabled, .ifc_seen);
   ibus_ctrl_model i_bus (.clk, .nrfd_n(nrfd_w), .ndac_n(ndac_w),
      .dio_n(m_dio), .dav_n, .atn_n, .eoi_n, .ifc_n, .ren_n);

   // Pulled-up wires: released means high
   assign pp_pull = (dio_n_oe && dio_n_out === 1'b0) ?
                    8'h01 << pp_line : 8'h00;
   assign dio_w = m_dio & ~pp_pull;
   assign nrfd_w = nrfd_n_oe ? nrfd_n_out : 1'b1;
   assign ndac_w = ndac_n_oe ? ndac_n_out : 1'b1;
   always #4 clk = ~clk;
   always @(negedge clk) if (rnd_rdy) rx_ready <= 1'($urandom % 2);
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) begin
         got <= cmd;
         n_cmd <= n_cmd + 1;
      end
      if (rx_valid === 1'b1 && rx_ready === 1'b1)
         check({rx_eom, rx_data},
               exp_q.size() > 0 ? exp_q.pop_front() : 9'bx);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   function automatic ibus_pkg::cmd_s dec(input logic [6:0] c);
      dec = '0;
      dec.listen = c >= 7'h20 && c <= 7'h3E;
      dec.unlisten = c == 7'h3F;
      dec.talk = c >= 7'h40 && c <= 7'h5E;
      dec.untalk = c == 7'h5F;
      dec.second = c >= 7'h60 && c <= 7'h7E;
      dec.pp_enable = cfg && c >= 7'h60 && c <= 7'h6F;
      dec.pp_disable = cfg && c >= 7'h70 && c <= 7'h7E;
      dec.addr = 5'(c - (c < 7'h40 ? 7'h20 : c < 7'h60 ? 7'h40 : 7'h60));
   endfunction

   task automatic cmd_byte(input logic [7:0] b);
      int k;
      logic [11:0] m;
      logic [6:0] c;
      c = b[6:0];
      k = n_cmd;
      i_bus.send(b, 1'b1, 1'b0, ok);
      check(ok, 1'b1);
      for (n = 0; n < 8 && n_cmd == k; n++) @(negedge clk);
      check(n_cmd - k, 1);
      if (c != 7'h05) begin
         m = (c == 7'h3F || c == 7'h5F) ? 12'hFE0 : 12'hFFF;
         check(got & m, dec(c) & m);
      end
      l = (c == 7'h3F) ? 1'b0 : (c == 7'h20 + 7'(my)) | l;
      if (c >= 7'h40 && c <= 7'h5F) t = c == 7'h40 + 7'(my);
      if (cfg && c >= 7'h60) p = c < 7'h70;
      if (cfg && c >= 7'h60) pl = c[2:0];
      cfg = c == 7'h05 && l;
      @(negedge clk);
      check({talker, listener, poll_enabled}, {t, l, p});
   endtask

   task automatic data_byte(input logic [7:0] b, input logic e,
                            input logic want);
      i_bus.slow = $urandom % 3;
      // Expected first: the word can leave the buffer before send returns
      if (l) exp_q.push_back({e, b});
      i_bus.send(b, 1'b0, e, ok);
      check(ok, want);
      if (l && !ok) void'(exp_q.pop_back());
   endtask

   task automatic drain(input string s);
      for (n = 0; n < 300 && exp_q.size() > 0; n++) @(negedge clk);
      check(exp_q.size(), 0);
      $display("end of test %s", s);
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(42879));
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      foreach (cmds[i]) cmd_byte(cmds[i]);
      cmd_byte(8'h21);
      rnd_rdy = 1'b1;
      for (int i = 0; i < 6; i++) data_byte(8'($urandom), i == 5, 1'b1);
      drain("data");
      rnd_rdy = 1'b0;
      @(negedge clk);
      rx_ready = 1'b0;
      for (int i = 0; i <= dp; i++) data_byte(8'($urandom), 1'b0, i < dp);
      // Commands still pass while full; the next data byte must stall
      cmd_byte(8'h21);
      data_byte(8'($urandom), 1'b0, 1'b0);
      rx_ready = 1'b1;
      drain("fifo");
      cmd_byte(8'h3F);
      data_byte(8'hA5, 1'b0, 1'b1);
      check({nrfd_n_oe, ndac_n_oe, rx_valid}, 3'b000);
      cmd_byte(8'h21);
      cmd_byte(8'h05);
      cmd_byte(8'h6B);
      i_bus.eoi_n = 1'b0;
      for (n = 0; n < 8 && dio_n_oe !== 1'b1; n++) @(negedge clk);
      check(dio_w, 8'hFF ^ (8'h01 << pl));
      check(pp_line, pl);
      i_bus.eoi_n = 1'b1;
      cmd_byte(8'h05);
      cmd_byte(8'h77);
      i_bus.eoi_n = 1'b0;
      repeat (6) @(negedge clk);
      check(dio_n_oe, 1'b0);
      i_bus.eoi_n = 1'b1;
      srq_req = 1'b1;
      @(negedge clk);
      check({srq_n_oe, srq_n_out}, 2'b10);
      srq_req = 1'b0;
      @(negedge clk);
      check(srq_n_oe, 1'b0);
      i_bus.ren_n = 1'b0;
      for (n = 0; n < 8 && remote !== 1'b1; n++) @(negedge clk);
      check(remote, 1'b1);
      cmd_byte(8'h21);
      cmd_byte(8'h41);
      i_bus.ifc_n = 1'b0;
      for (n = 0; n < 8 && ifc_seen !== 1'b1; n++) @(negedge clk);
      @(negedge clk);
      check({ifc_seen, talker, listener}, 3'b100);
      i_bus.ifc_n = 1'b1;
      $display("end of test lines");
      report_and_stop();
   end

   initial begin
      #400000;
      mismatches++;
      report_and_stop();
   end
endmodule
